// >>> src/sms_pkg.sv
// Purpose: Shared constants and types for the sensor measurement sequencer.
// Assumes: 100 MHz core clock; step timing as below.
// Notes: Summary of operation follows.
//
// Summary of operation
// R1: After reset, sleep and measure nothing.
// R2: Power-on bit set moves sleep to start.
// R3: Phases run proximity, then wait, then light.
// R4: A disabled phase does nothing, passes through.
// R5: Power-on cleared: finish conversion, then sleep.
// R6: Power-on control is register zero, bit zero.
// R7: Wait lasts 1 to 256 steps of 2.72 ms.
// R8: Two concurrent integrating converters, one per photodiode.
// R9: Duration is 2.72 ms times (256 - setting).
// R10: Both counts copied together at conversion end.
// R11: While powered, loop back to proximity forever.
// R12: Setting 0xff gives one step, lower adds more.
package sms_pkg;

  ////////////////////////////////////////////////////////////////////////////
  // Control location of the power-on bit
  localparam int POWER_ON_REG_IDX = 0; // see R6
  localparam int POWER_ON_BIT_POS = 0; // see R6

  ////////////////////////////////////////////////////////////////////////////
  // Step timing
  localparam int CLK_PERIOD_NS = 10; // Core clock period
  localparam int STEP_TIME_NS = 2720000; // One integration or wait step
  // Cycles per step, rounded up
  localparam int STEP_CYCLES = (STEP_TIME_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam logic [8:0] STEPS_FULL = 9'h100; // Step count base

  ////////////////////////////////////////////////////////////////////////////
  // Reset values and limits
  localparam logic [15:0] COUNT_RST = 16'h0000; // Channel counts after reset
  localparam logic [15:0] COUNT_MAX = 16'hffff; // Saturation value
  localparam logic [7:0] SETTING_RST = 8'hff; // Idle timer setting

  ////////////////////////////////////////////////////////////////////////////
  // Sequencer states
  typedef enum logic [2:0] {
    SMS_SLEEP,
    SMS_START,
    SMS_PROX,
    SMS_WAIT,
    SMS_LIGHT
  } sms_state_t;

endpackage

// >>> src/sms_timer_if.sv
// Purpose: Carries step-timer control between sequencer and timer.
// Assumes: Single clock domain.
// Notes: Start restarts the timer and suppresses a stale done; halt abandons a count.
`timescale 1ns/1ps
interface sms_timer_if;
  logic start; // One-cycle launch
  logic [7:0] setting; // Two's complement step setting
  logic done; // One-cycle end of last step
  logic busy; // Steps remaining
  logic halt; // Abandon the running count
  modport ctrl (output start, output setting, output halt, input done, input busy);
  modport tmr (input start, input setting, input halt, output done, output busy);
endinterface

// >>> src/sms_step_timer.sv
// Purpose: Counts 256 minus setting steps of STEP_CYCLES cycles each.
// Assumes: Start is a single-cycle pulse from the sequencer.
// Notes: Done pulses one cycle after the last step ends.
`timescale 1ns/1ps
module sms_step_timer #(
  parameter int STEP_CYCLES = sms_pkg::STEP_CYCLES
) (
  // Clock and reset
  input wire logic clk_in,
  input wire logic nrst_in,
  // Timer control
  sms_timer_if.tmr tb
);

  localparam int CYC_W = $clog2(STEP_CYCLES + 1);
  localparam logic [CYC_W-1:0] CYC_LAST = CYC_W'(STEP_CYCLES - 1);

  logic [CYC_W-1:0] cyc; // Cycles into current step
  logic [CYC_W-1:0] next_cyc;
  logic [8:0] steps; // Steps left
  logic [8:0] next_steps;
  logic done; // Done pulse
  logic next_done;

  ////////////////////////////////////////////////////////////////////////////
  // Next step and cycle counts
  always_comb begin
    next_cyc = cyc;
    next_steps = steps;
    next_done = 1'b0;
    if (tb.start) begin
      // Two's complement step count, 0xff gives one step
      next_steps = sms_pkg::STEPS_FULL - {1'b0, tb.setting}; // see R9 see R12
      next_cyc = '0;
    end else if (tb.halt) begin
      // Sequencer gave up the phase; stop so sleep stays idle
      next_steps = 9'h000; // see R1
      next_cyc = '0;
    end else if (steps != 9'h000) begin
      if (cyc == CYC_LAST) begin
        next_cyc = '0;
        next_steps = steps - 9'h001;
        next_done = (steps == 9'h001); // see R7
      end else begin
        next_cyc = cyc + CYC_W'(1);
      end
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Timer registers
  always_ff @(posedge clk_in or negedge nrst_in) begin
    if (!nrst_in) begin
      cyc <= '0;
      steps <= 9'h000;
      done <= 1'b0;
    end else begin
      cyc <= next_cyc;
      steps <= next_steps;
      done <= next_done;
    end
  end

  assign tb.done = done;
  assign tb.busy = (steps != 9'h000);

  ////////////////////////////////////////////////////////////////////////////
  // Checks
  a_step_load_count: assert property (@(posedge clk_in) disable iff (!nrst_in) // see R12
    tb.start |=> steps == 9'h100 - {1'b0, $past(tb.setting)})
    else $error("step count not 256 minus setting");
  a_done_last_step: assert property (@(posedge clk_in) disable iff (!nrst_in) // see R7
    (!tb.start && steps == 9'h001 && cyc == CYC_LAST) |=> done && steps == 9'h000)
    else $error("done missing after last step");
  a_halt_clears: assert property (@(posedge clk_in) disable iff (!nrst_in) // see R1
    (tb.halt && !tb.start) |=> steps == 9'h000 && !done)
    else $error("halt left the timer running");

endmodule

// >>> src/sms_sequencer.sv
// Purpose: Top state machine: sleep, start, proximity, wait, light phases.
// Assumes: Enables and settings come from host logic on clk_in.
// Notes: Photodiode pulse inputs are asynchronous and synchronised here.
`timescale 1ns/1ps
module sms_sequencer #(
  parameter int STEP_CYCLES = sms_pkg::STEP_CYCLES // Cycles per step
) (
  // Clock and reset
  input wire logic clk_in,
  input wire logic nrst_in,
  // Control bits from host
  input wire logic power_on_bit_in,
  input wire logic prox_enable_in,
  input wire logic wait_enable_in,
  input wire logic light_enable_in,
  // Timing settings from host
  input wire logic [7:0] prox_integration_setting_in,
  input wire logic [7:0] wait_duration_setting_in,
  input wire logic [7:0] light_integration_setting_in,
  // Converter pulses from photodiode front end
  input wire logic broadband_pulse_in,
  input wire logic infrared_pulse_in,
  // Status
  output sms_pkg::sms_state_t phase_out,
  output logic sleeping_out,
  output logic data_ready_out,
  // Channel data
  output logic [15:0] broadband_channel_count_out,
  output logic [15:0] infrared_channel_count_out
);

  ////////////////////////////////////////////////////////////////////////////
  // Saturating increment shared by both converters
  function automatic logic [15:0] sat_inc(input logic [15:0] v);
    sat_inc = (v == sms_pkg::COUNT_MAX) ? v : v + 16'h0001;
  endfunction

  sms_timer_if tmr_bus ();

  sms_pkg::sms_state_t state; // Current phase
  sms_pkg::sms_state_t next_state;
  logic run; // Phase is doing its work
  logic next_run;
  logic tstart; // Timer launch
  logic thalt; // Timer abort
  logic [7:0] tset; // Timer setting
  logic [15:0] bb_acc; // Broadband integrator
  logic [15:0] next_bb_acc;
  logic [15:0] ir_acc; // Infrared integrator
  logic [15:0] next_ir_acc;
  logic [15:0] next_bb_out;
  logic [15:0] next_ir_out;
  logic next_ready;
  logic [2:0] bb_sync; // Sync stages plus edge history
  logic [2:0] ir_sync;
  logic bb_rise; // Broadband pulse edge
  logic ir_rise; // Infrared pulse edge

  ////////////////////////////////////////////////////////////////////////////
  // Step timer
  sms_step_timer #(.STEP_CYCLES(STEP_CYCLES)) u_timer (
    .clk_in(clk_in),
    .nrst_in(nrst_in),
    .tb(tmr_bus.tmr)
  );
  assign tmr_bus.start = tstart;
  assign tmr_bus.setting = tset;
  assign tmr_bus.halt = thalt;

  ////////////////////////////////////////////////////////////////////////////
  // Pulse synchronisers; stage 0 feeds only stage 1
  always_ff @(posedge clk_in or negedge nrst_in) begin
    if (!nrst_in) begin
      bb_sync <= 3'h0;
      ir_sync <= 3'h0;
    end else begin
      bb_sync <= {bb_sync[1:0], broadband_pulse_in};
      ir_sync <= {ir_sync[1:0], infrared_pulse_in};
    end
  end
  assign bb_rise = bb_sync[1] && !bb_sync[2];
  assign ir_rise = ir_sync[1] && !ir_sync[2];

  ////////////////////////////////////////////////////////////////////////////
  // Sequencer next state
  always_comb begin
    next_state = state;
    next_run = run;
    tstart = 1'b0;
    thalt = 1'b0;
    tset = sms_pkg::SETTING_RST;
    next_bb_acc = bb_acc;
    next_ir_acc = ir_acc;
    next_bb_out = broadband_channel_count_out;
    next_ir_out = infrared_channel_count_out;
    next_ready = 1'b0;
    case (state)
      sms_pkg::SMS_SLEEP: begin
        // Stay asleep until powered on
        next_run = 1'b0;
        if (power_on_bit_in) begin
          next_state = sms_pkg::SMS_START; // see R1 see R2 see R6
        end
      end
      sms_pkg::SMS_START: begin
        if (!power_on_bit_in) begin
          next_state = sms_pkg::SMS_SLEEP;
        end else begin
          // Enter proximity; launch only when enabled
          next_state = sms_pkg::SMS_PROX; // see R3
          next_run = prox_enable_in; // see R4
          tstart = prox_enable_in;
          tset = prox_integration_setting_in;
        end
      end
      sms_pkg::SMS_PROX: begin
        // Conversion runs to completion even if powered off
        if (!run || tmr_bus.done) begin // see R5
          next_run = 1'b0;
          if (!power_on_bit_in) begin
            next_state = sms_pkg::SMS_SLEEP;
          end else begin
            next_state = sms_pkg::SMS_WAIT; // see R3
            next_run = wait_enable_in; // see R4
            tstart = wait_enable_in; // see R7
            tset = wait_duration_setting_in;
          end
        end
      end
      sms_pkg::SMS_WAIT: begin
        // Wait holds no conversion, so power-off ends it at once
        if (!power_on_bit_in) begin
          next_state = sms_pkg::SMS_SLEEP;
          next_run = 1'b0;
          thalt = 1'b1; // see R1
        end else if (!run || tmr_bus.done) begin
          next_state = sms_pkg::SMS_LIGHT; // see R3
          next_run = light_enable_in; // see R4
          tstart = light_enable_in;
          tset = light_integration_setting_in;
          next_bb_acc = sms_pkg::COUNT_RST;
          next_ir_acc = sms_pkg::COUNT_RST;
        end
      end
      sms_pkg::SMS_LIGHT: begin
        if (run) begin
          // Both channels integrate side by side
          if (bb_rise) begin
            next_bb_acc = sat_inc(bb_acc); // see R8
          end
          if (ir_rise) begin
            next_ir_acc = sat_inc(ir_acc); // see R8
          end
        end
        if (!run || tmr_bus.done) begin // see R5
          if (run) begin
            // Copy both counts in the same edge
            next_bb_out = bb_acc; // see R10
            next_ir_out = ir_acc; // see R10
            next_ready = 1'b1;
          end
          next_run = 1'b0;
          // Loop back through start to proximity
          next_state = power_on_bit_in ? sms_pkg::SMS_START : sms_pkg::SMS_SLEEP; // see R11
        end
      end
      default: begin
        next_state = sms_pkg::SMS_SLEEP;
        next_run = 1'b0;
      end
    endcase
  end

  ////////////////////////////////////////////////////////////////////////////
  // Sequencer registers
  always_ff @(posedge clk_in or negedge nrst_in) begin
    if (!nrst_in) begin
      state <= sms_pkg::SMS_SLEEP; // see R1
      run <= 1'b0;
      bb_acc <= sms_pkg::COUNT_RST;
      ir_acc <= sms_pkg::COUNT_RST;
      broadband_channel_count_out <= sms_pkg::COUNT_RST;
      infrared_channel_count_out <= sms_pkg::COUNT_RST;
      data_ready_out <= 1'b0;
      sleeping_out <= 1'b1;
    end else begin
      state <= next_state;
      run <= next_run;
      bb_acc <= next_bb_acc;
      ir_acc <= next_ir_acc;
      broadband_channel_count_out <= next_bb_out;
      infrared_channel_count_out <= next_ir_out;
      data_ready_out <= next_ready;
      sleeping_out <= (next_state == sms_pkg::SMS_SLEEP);
    end
  end

  assign phase_out = state;

  ////////////////////////////////////////////////////////////////////////////
  // Checks
  a_sleep_holds_off: assert property (@(posedge clk_in) disable iff (!nrst_in) // see R1
    (state == sms_pkg::SMS_SLEEP && !power_on_bit_in) |=>
      state == sms_pkg::SMS_SLEEP && !run && !tmr_bus.busy)
    else $error("activity while asleep");
  a_power_on_start: assert property (@(posedge clk_in) disable iff (!nrst_in) // see R2
    (state == sms_pkg::SMS_SLEEP && power_on_bit_in) |=> state == sms_pkg::SMS_START)
    else $error("power-on did not reach start");
  a_phase_order: assert property (@(posedge clk_in) disable iff (!nrst_in) // see R3
    (state == sms_pkg::SMS_PROX && next_state != sms_pkg::SMS_PROX) |=>
      state inside {sms_pkg::SMS_WAIT, sms_pkg::SMS_SLEEP})
    else $error("proximity not followed by wait");
  a_disabled_passes: assert property (@(posedge clk_in) disable iff (!nrst_in) // see R4
    (state == sms_pkg::SMS_START && power_on_bit_in && !prox_enable_in) |=>
      state == sms_pkg::SMS_PROX && !run ##1 state != sms_pkg::SMS_PROX)
    else $error("disabled proximity did work");
  a_finish_then_sleep: assert property (@(posedge clk_in) disable iff (!nrst_in) // see R5
    (state == sms_pkg::SMS_LIGHT && run && !tmr_bus.done && !power_on_bit_in) |=>
      state == sms_pkg::SMS_LIGHT)
    else $error("conversion cut short by power-off");
  a_wait_launch: assert property (@(posedge clk_in) disable iff (!nrst_in) // see R7
    (state == sms_pkg::SMS_PROX && next_state == sms_pkg::SMS_WAIT && wait_enable_in) |=>
      tmr_bus.busy && run)
    else $error("wait timer not launched");
  a_counts_copied: assert property (@(posedge clk_in) disable iff (!nrst_in) // see R10
    (state == sms_pkg::SMS_LIGHT && run && tmr_bus.done) |=>
      data_ready_out && broadband_channel_count_out == $past(bb_acc) &&
      infrared_channel_count_out == $past(ir_acc))
    else $error("channel counts not copied together");
  a_cycle_repeats: assert property (@(posedge clk_in) disable iff (!nrst_in) // see R11
    (state == sms_pkg::SMS_LIGHT && !run && power_on_bit_in) |=>
      state == sms_pkg::SMS_START ##1 state == sms_pkg::SMS_PROX)
    else $error("cycle did not repeat");
  a_channel_count: assert property (@(posedge clk_in) disable iff (!nrst_in) // see R8
    (state == sms_pkg::SMS_LIGHT && run && bb_rise && bb_acc != sms_pkg::COUNT_MAX) |=>
      bb_acc == $past(bb_acc) + 16'h0001)
    else $error("broadband edge not counted");

endmodule

// >>> verif/sms_host_model.sv
// Purpose: Host side model holding the control registers of the sequencer.
// Assumes: Writes land on the rising edge where wr_in is high.
// Notes: Reg0 bit0 power, bit1 prox, bit2 wait, bit3 light enable.
`timescale 1ns/1ps
module sms_host_model (
  // Clock and reset
  input wire logic clk_in,
  input wire logic nrst_in,
  // Write port
  input wire logic wr_in,
  input wire logic [1:0] idx_in,
  input wire logic [7:0] data_in,
  // Control outputs
  output logic [3:0] ctl_out,
  output logic [7:0] light_set_out,
  output logic [7:0] prox_set_out,
  output logic [7:0] wait_set_out
);
  logic [7:0] regs [4]; // Control register file
  ////////////////////////////////////////////////////////////////////////////
  // Register writes, power off and shortest times after reset
  always_ff @(posedge clk_in or negedge nrst_in) begin
    if (!nrst_in) begin
      regs <= '{8'h00, 8'hff, 8'hff, 8'hff};
    end else if (wr_in) begin
      regs[idx_in] <= data_in;
    end
  end
  assign ctl_out = regs[0][3:0]; // Power on sits at bit 0
  assign light_set_out = regs[1];
  assign prox_set_out = regs[2];
  assign wait_set_out = regs[3];
endmodule

// >>> verif/tb_sms_sequencer.sv
// Purpose: Self-checking bench for the measurement sequencer.
// Assumes: Short step of STEPS cycles; inputs driven 1 ns after the edge.
// Notes: A monitor logs each finished phase with its length.
`timescale 1ns/1ps
module tb_sms_sequencer;
  localparam int STEPS = 4; // Short step for simulation
  logic clk_in, nrst_in, wr, bb_p, ir_p;
  logic [1:0] wr_idx;
  logic [7:0] wr_data, lset, pset, wset;
  logic [3:0] ctl;
  sms_pkg::sms_state_t phase, prev;
  logic sleeping, ready;
  logic [15:0] bb_cnt, ir_cnt;
  int error_cnt, checks_done, cycles, seed, exp_bb, exp_ir, ready_seen, run_len, ps, ws;
  sms_pkg::sms_state_t q_ph[$]; // Finished phases
  int q_len[$]; // Their lengths in cycles
  ////////////////////////////////////////////////////////////////////////////
  // Design, host model and clock
  sms_host_model host_u (.clk_in(clk_in), .nrst_in(nrst_in), .wr_in(wr), .idx_in(wr_idx),
    .data_in(wr_data), .ctl_out(ctl), .light_set_out(lset), .prox_set_out(pset),
    .wait_set_out(wset));
  sms_sequencer #(.STEP_CYCLES(STEPS)) dut_u (.clk_in(clk_in), .nrst_in(nrst_in),
    .power_on_bit_in(ctl[0]), .prox_enable_in(ctl[1]), .wait_enable_in(ctl[2]),
    .light_enable_in(ctl[3]), .prox_integration_setting_in(pset),
    .wait_duration_setting_in(wset), .light_integration_setting_in(lset),
    .broadband_pulse_in(bb_p), .infrared_pulse_in(ir_p), .phase_out(phase),
    .sleeping_out(sleeping), .data_ready_out(ready),
    .broadband_channel_count_out(bb_cnt), .infrared_channel_count_out(ir_cnt));
  initial begin
    clk_in = 1'b0;
    forever #5 clk_in = ~clk_in;
  end
  ////////////////////////////////////////////////////////////////////////////
  // Shared tasks
  task automatic close_out();
    $display("checks=%0d errors=%0d", checks_done, error_cnt);
    if (error_cnt == 0 && checks_done > 0) begin
      $display("SIMULATION PASSED");
    end else begin
      $display("SIMULATION FAILED");
    end
    $finish;
  endtask
  task automatic check(input logic [31:0] got, input logic [31:0] exp);
    checks_done++;
    if (got !== exp) begin
      error_cnt++;
      $display("[ERR] t=%0t got=%0h exp=%0h", $time, got, exp);
    end
  endtask
  // Pop one finished phase and compare kind and length range
  task automatic pop(input sms_pkg::sms_state_t p, input int lo, input int hi);
    int n;
    n = 0;
    while (q_ph.size() == 0 && n < 3000) begin
      @(posedge clk_in);
      n++;
    end
    if (q_ph.size() == 0) begin
      error_cnt++;
      close_out();
    end
    check({29'h0, q_ph[0]}, {29'h0, p});
    checks_done++;
    if (q_len[0] < lo || q_len[0] > hi) begin
      error_cnt++;
      $display("[ERR] t=%0t len=%0h exp=%0h", $time, q_len[0], lo);
    end
    void'(q_ph.pop_front());
    void'(q_len.pop_front());
  endtask
  task automatic wait_for(input sms_pkg::sms_state_t p);
    int n;
    n = 0;
    do begin
      @(posedge clk_in);
      #3;
      n++;
    end while (phase !== p && n < 3000);
    if (phase !== p) begin
      error_cnt++;
      close_out();
    end
  endtask
  task automatic host_wr(input logic [1:0] idx, input logic [7:0] d);
    @(posedge clk_in);
    #1 wr = 1'b1;
    wr_idx = idx;
    wr_data = d;
    @(posedge clk_in);
    #1 wr = 1'b0;
  endtask
  // Both channels pulse together, 2 cycles high and 2 low
  task automatic pulses(input int nb, input int ni);
    for (int k = 0; k < 10; k++) begin
      @(posedge clk_in);
      #1 bb_p = (k < nb);
      ir_p = (k < ni);
      repeat (2) @(posedge clk_in);
      #1 bb_p = 1'b0;
      ir_p = 1'b0;
      @(posedge clk_in);
    end
  endtask
  ////////////////////////////////////////////////////////////////////////////
  // Monitor: phase log, result compare against expected counts, timeout
  always @(posedge clk_in) begin
    #2 cycles++;
    if (cycles == 6000) begin
      error_cnt++;
      close_out();
    end
    if (phase !== prev) begin
      q_ph.push_back(prev);
      q_len.push_back(run_len);
      run_len = 1;
      prev = phase;
    end else begin
      run_len++;
    end
    if (ready === 1'b1) begin
      ready_seen++;
      check({16'h0, bb_cnt}, exp_bb);
      check({16'h0, ir_cnt}, exp_ir);
    end
  end
  ////////////////////////////////////////////////////////////////////////////
  // Main sequence
  initial begin
    {wr, bb_p, ir_p, wr_idx, wr_data} = '0;
    {error_cnt, checks_done, cycles, ready_seen, run_len} = '0;
    prev = sms_pkg::SMS_SLEEP;
    seed = 32'h71d5a18a;
    nrst_in = 1'b0;
    repeat (12) @(posedge clk_in);
    #1 nrst_in = 1'b1;
    repeat (20) @(posedge clk_in);
    #3 check({29'h0, phase}, {29'h0, sms_pkg::SMS_SLEEP});
    check({31'h0, sleeping}, 1);
    check({16'h0, bb_cnt}, 0);
    $display("test reset done");
    ps = 1 + $unsigned($random(seed)) % 6;
    ws = 1 + $unsigned($random(seed)) % 8;
    exp_bb = $unsigned($random(seed)) % 11;
    exp_ir = $unsigned($random(seed)) % 11;
    host_wr(2'h2, 8'(256 - ps));
    host_wr(2'h3, 8'(256 - ws));
    host_wr(2'h1, 8'hf0);
    host_wr(2'h0, 8'h0f);
    wait_for(sms_pkg::SMS_LIGHT);
    pulses(exp_bb, exp_ir);
    host_wr(2'h3, 8'hff);
    host_wr(2'h0, 8'h05);
    pop(sms_pkg::SMS_SLEEP, 1, 9999);
    pop(sms_pkg::SMS_START, 1, 1);
    pop(sms_pkg::SMS_PROX, ps * STEPS + 1, ps * STEPS + 2);
    pop(sms_pkg::SMS_WAIT, ws * STEPS + 1, ws * STEPS + 2);
    pop(sms_pkg::SMS_LIGHT, 16 * STEPS + 1, 16 * STEPS + 2);
    check(ready_seen, 1);
    $display("test full loop done");
    pop(sms_pkg::SMS_START, 1, 1);
    pop(sms_pkg::SMS_PROX, 1, 1);
    pop(sms_pkg::SMS_WAIT, STEPS + 1, STEPS + 2);
    pop(sms_pkg::SMS_LIGHT, 1, 1);
    check(ready_seen, 1);
    check({16'h0, bb_cnt}, exp_bb);
    $display("test disabled phases done");
    host_wr(2'h3, 8'h80);
    wait_for(sms_pkg::SMS_START);
    wait_for(sms_pkg::SMS_WAIT);
    q_ph.delete();
    q_len.delete();
    host_wr(2'h0, 8'h04);
    pop(sms_pkg::SMS_WAIT, 1, 8);
    #3 check({29'h0, phase}, {29'h0, sms_pkg::SMS_SLEEP});
    check({31'h0, sleeping}, 1);
    $display("test power off in wait done");
    exp_bb = $unsigned($random(seed)) % 11;
    exp_ir = $unsigned($random(seed)) % 11;
    host_wr(2'h3, 8'hff);
    host_wr(2'h0, 8'h0f);
    wait_for(sms_pkg::SMS_LIGHT);
    q_ph.delete();
    q_len.delete();
    host_wr(2'h0, 8'h0e);
    pulses(exp_bb, exp_ir);
    pop(sms_pkg::SMS_LIGHT, 16 * STEPS + 1, 16 * STEPS + 2);
    repeat (2) @(posedge clk_in);
    #3 check({29'h0, phase}, {29'h0, sms_pkg::SMS_SLEEP});
    check(ready_seen, 2);
    $display("test power off in light done");
    host_wr(2'h0, 8'h0f);
    wait_for(sms_pkg::SMS_PROX);
    q_ph.delete();
    q_len.delete();
    host_wr(2'h0, 8'h0e);
    pop(sms_pkg::SMS_PROX, ps * STEPS + 1, ps * STEPS + 2);
    #3 check({29'h0, phase}, {29'h0, sms_pkg::SMS_SLEEP});
    check({31'h0, sleeping}, 1);
    $display("test power off in prox done");
    close_out();
  end
endmodule
